/* File: hw/sync_comm_pkg.sv */
// Purpose: shared constants and types of the serial register access block
// Assumes: 50 MHz CLOCK, bit-serial host port
// Notes:   select offsets and field positions are named here only once
package sync_comm_pkg;
	localparam int SEL_W = 5;
	localparam int CRC_W = 16;
	localparam int CFG_W = 12;
	localparam int PAT_W = 10;
	localparam int IVL_W = 8;
	localparam int CHR_W = 9;
	localparam int NFLAG = 7;
	localparam int NEN   = 6;
	// -----------------------------------------------------------------
	// load flag and enable positions
	// -----------------------------------------------------------------
	localparam int FL_CFG  = 0;
	localparam int FL_PAT1 = 1;
	localparam int FL_PAT2 = 2;
	localparam int FL_IVL  = 3;
	localparam int FL_RXC  = 4;
	localparam int FL_TXC  = 5;
	localparam int FL_TXB  = 6;
	localparam int EN_MODEM = 0;
	localparam int EN_TIMER = 1;
	localparam int EN_ABORT = 2;
	localparam int EN_EMPTY = 3;
	localparam int EN_RX    = 4;
	localparam int EN_TXON  = 5;
	// -----------------------------------------------------------------
	// control register fields and output select offsets
	// -----------------------------------------------------------------
	localparam int CFG_RATE = 11;
	localparam int CFG_POLY = 9;
	localparam int CFG_MODE = 6;
	localparam logic [4:0] SEL_IVL_TOP = 5'h07;
	localparam logic [4:0] SEL_CHR_TOP = 5'h08;
	localparam logic [4:0] SEL_PAT_TOP = 5'h09;
	localparam logic [4:0] SEL_CFG_TOP = 5'h0B;
	localparam logic [4:0] SEL_LOW_TOP = 5'h0F;
	localparam logic [4:0] SEL_FLAG    = 5'h10;
	localparam logic [4:0] SEL_EN      = 5'h17;
	// -----------------------------------------------------------------
	// polynomials, reset values, timing
	// -----------------------------------------------------------------
	localparam logic [15:0] POLY_CRC16 = 16'h8005;
	localparam logic [15:0] POLY_CRC12 = 16'h080F;
	localparam logic [15:0] POLY_REV16 = 16'h4003;
	localparam logic [15:0] POLY_CCITT = 16'h1021;
	localparam int CRC12_TOP = 11;
	localparam logic [11:0] CFG_RST = 12'h000;
	localparam logic [9:0]  PAT_RST = 10'h000;
	localparam logic [7:0]  IVL_RST = 8'h00;
	localparam logic [8:0]  CHR_RST = 9'h000;
	localparam logic [15:0] CRC_RST = 16'h0000;
	localparam int CLOCK_NS = 20;
	localparam int TICK_NS  = 1000;
	localparam int TICK_CYC = TICK_NS / CLOCK_NS;
	typedef enum logic [1:0] {
		PS_CRC16 = 2'b00,
		PS_CRC12 = 2'b01,
		PS_REV16 = 2'b10,
		PS_CCITT = 2'b11
	} poly_t;
	typedef enum logic [2:0] {
		MD_GEN   = 3'b000,
		MD_FRAME = 3'b001,
		MD_SYNC1 = 3'b010,
		MD_SYNC2 = 3'b011,
		MD_SPARE = 3'b100,
		MD_ASY2  = 3'b101,
		MD_ASY1  = 3'b110,
		MD_OFF   = 3'b111
	} mode_t;
	typedef struct packed {
		logic       ce_n;
		logic [4:0] sel;
		logic       wbit;
		logic       strobe;
		logic       rx_level;
	} pins_t;
	typedef struct packed {
		logic cts;
		logic dsr;
		logic auto_send_request;
		logic modem_status_changed;
		logic tx_abort;
		logic rx_buffer_loaded;
		logic frame_abort;
		logic start_bit_seen;
		logic frame_holding_loaded;
		logic first_bit_seen;
		logic frame_holding_overrun;
		logic framing_error;
		logic rx_overrun;
		logic parity_error;
		logic receive_error;
		logic zero_error;
		logic flag_detected;
	} rx_status_t;
endpackage

/* File: hw/check_sum_reg.sv */
// Purpose: one bit-serial check-sum register
// Assumes: shift is a one-cycle pulse per host bit
// Notes:   short polynomial leaves junk in the top nibble
`timescale 1ns/1ps
`default_nettype none
module check_sum_reg #(
	parameter int W = 16
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic                 shift,
	input  wire logic                 din,
	input  wire sync_comm_pkg::poly_t poly,
	output logic [W-1:0]              crc
);
	logic [W-1:0] crc_q;
	logic [W-1:0] crc_d;
	logic [W-1:0] taps;
	logic         fb;

	if (W != sync_comm_pkg::CRC_W) begin : g_chk
		$error("check_sum_reg width must be 16");
	end

	always_comb begin
		fb = din ^ crc_q[W-1];
		case (poly)
			sync_comm_pkg::PS_CRC16: taps = sync_comm_pkg::POLY_CRC16;
			sync_comm_pkg::PS_CRC12: begin
				taps = sync_comm_pkg::POLY_CRC12;
				fb   = din ^ crc_q[sync_comm_pkg::CRC12_TOP];
			end
			sync_comm_pkg::PS_REV16: taps = sync_comm_pkg::POLY_REV16;
			default:                 taps = sync_comm_pkg::POLY_CCITT;
		endcase
		crc_d = crc_q;
		if (shift) begin
			crc_d = {crc_q[W-2:0], 1'b0} ^ (fb ? taps : '0);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			crc_q <= sync_comm_pkg::CRC_RST;
		end else begin
			crc_q <= crc_d;
		end
	end

	assign crc = crc_q;
endmodule
`default_nettype wire

/* File: hw/interval_timer.sv */
// Purpose: interval timer that reloads from the interval register
// Assumes: TICK cycles of CLOCK make one timer step
// Notes:   an interval of zero stops the events
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
	parameter int W    = 8,
	parameter int TICK = 50
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] interval,
	output logic              elapsed
);
	localparam int PW = $clog2(TICK);
	logic [PW-1:0] pre_q;
	logic [PW-1:0] pre_d;
	logic [W-1:0]  cnt_q;
	logic [W-1:0]  cnt_d;
	logic          el_q;
	logic          el_d;

	if (TICK < 2) begin : g_chk
		$error("interval_timer TICK must be at least 2");
	end

	always_comb begin
		pre_d = pre_q - 1'b1;
		cnt_d = cnt_q;
		el_d  = 1'b0;
		if (pre_q == '0) begin
			pre_d = PW'(TICK - 1);
			if (interval != '0) begin
				if (cnt_q == '0) begin
					cnt_d = interval;
				end else if (cnt_q == W'(1)) begin
					cnt_d = interval; // [RULE25]
					el_d  = 1'b1; // [RULE2]
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pre_q <= '0;
			cnt_q <= '0;
			el_q  <= 1'b0;
		end else begin
			pre_q <= pre_d;
			cnt_q <= cnt_d;
			el_q  <= el_d;
		end
	end

	assign elapsed = el_q;
endmodule
`default_nettype wire

/* File: hw/sync_comm_regs.sv */
// Purpose: bit-addressed register access of the communication controller
// Assumes: host pins are asynchronous; engine status is on CLOCK
// Notes:   read data lags select and enable pins by three cycles
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: interval register takes bit writes only while its load flag is set
// RULE2: interval register value sets the timer event rate
// RULE3: receive check-sum advances on writes to bits 0-9 under its flag
// RULE4: receive check-sum is read on bits 0-15 under its flag
// RULE5: check-sum reads come out most significant bit first
// RULE6: transmit check-sum advances on bits 0-9 under either tx flag
// RULE7: transmit check-sum is read on bits 0-15 under either tx flag
// RULE8: tx and pattern load flags stay set until an explicit command
// RULE9: first pattern register takes bits 0-9 under its flag
// RULE10: second pattern register takes bits 0-9 under its flag
// RULE11: first pattern syncs receive and fills; second only fills
// RULE12: tx buffer loads with no flag set or the buffer-check flag
// RULE13: active transmitter moves buffer to shifter when a char ends
// RULE14: buffer-check flag loads bits 0-8 and advances tx check-sum
// RULE15: host reads one of 32 bits chosen by select lines under enable
// RULE16: read line released when chip enable is high
// RULE17: bits 0-15 show normal data only with all load flags clear
// RULE18: bits 31-21 carry summary, flag and status bits
// RULE19: bits 20-16 carry enabled interrupts, bit 15 receive level
// RULE20: bits 14-9 carry mode dependent receive status
// RULE21: bits 8-0 carry the received character
// RULE22: check-sums shift once per host write strobe
// RULE23: any write to control bit 11 clears the control load flag
// RULE24: flag status bit is the OR of all seven load flags
// RULE25: timer reloads from interval register at each expiry
module sync_comm_regs #(
	parameter int TICK_CYC = sync_comm_pkg::TICK_CYC
) (
	input  wire logic                       CLOCK,
	input  wire logic                       SYS_RST,
	input  wire logic                       CE_N,
	input  wire logic [4:0]                 BIT_SELECT_LINES,
	input  wire logic                       SERIAL_WRITE_LINE,
	input  wire logic                       SERIAL_BIT_STROBE,
	input  wire logic                       SERIAL_RECEIVE_LEVEL,
	input  wire sync_comm_pkg::rx_status_t  STATUS,
	input  wire logic [8:0]                 RX_CHAR,
	input  wire logic                       RX_CHAR_VALID,
	input  wire logic                       TX_CHAR_DONE,
	output logic                            SERIAL_READ_LINE,
	output logic                            SERIAL_READ_OE,
	output logic [11:0]                     CONFIG,
	output logic [9:0]                      SYNC_PATTERN,
	output logic [9:0]                      FILL_PATTERN,
	output logic [8:0]                      TX_SHIFTER,
	output logic                            TX_SHIFT_LOAD,
	output logic                            TX_ACTIVE
);
	localparam int NF = sync_comm_pkg::NFLAG;
	localparam int NE = sync_comm_pkg::NEN;

	if (TICK_CYC < 2) begin : g_chk
		$error("TICK_CYC must be at least 2");
	end

	// -----------------------------------------------------------------
	// pin synchronisers
	// -----------------------------------------------------------------
	sync_comm_pkg::pins_t meta_q;
	sync_comm_pkg::pins_t pin_q;
	logic                 strobe_prev_q;
	logic                 wr;

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			meta_q        <= '{ce_n: 1'b1, default: '0};
			pin_q         <= '{ce_n: 1'b1, default: '0};
			strobe_prev_q <= 1'b0;
		end else begin
			meta_q        <= '{ce_n: CE_N, sel: BIT_SELECT_LINES,
				wbit: SERIAL_WRITE_LINE, strobe: SERIAL_BIT_STROBE,
				rx_level: SERIAL_RECEIVE_LEVEL};
			pin_q         <= meta_q;
			strobe_prev_q <= pin_q.strobe;
		end
	end

	// one write per rising strobe edge, only while the chip is enabled
	assign wr = pin_q.strobe && !strobe_prev_q && !pin_q.ce_n; // [RULE22]

	// -----------------------------------------------------------------
	// write decode and register state
	// -----------------------------------------------------------------
	logic [NF-1:0] flag_q, flag_d;
	logic [NE-1:0] en_q, en_d;
	logic [11:0]   cfg_q, cfg_d;
	logic [9:0]    pat1_q, pat1_d;
	logic [9:0]    pat2_q, pat2_d;
	logic [9:0]    fill_q, fill_d;
	logic [7:0]    ivl_q, ivl_d;
	logic [8:0]    xbr_q, xbr_d;
	logic [8:0]    xsr_q, xsr_d;
	logic          empty_q, empty_d;
	logic          load_q, load_d;
	logic          elap_q, elap_d;
	logic          miss_q, miss_d;
	logic          rx_shift, tx_shift;
	logic          tick;
	logic [15:0]   rx_crc, tx_crc;
	logic [4:0]    sel;
	logic [4:0]    cmd;
	logic          any_flag;
	sync_comm_pkg::mode_t mode;

	assign sel      = pin_q.sel;
	assign any_flag = |flag_q; // [RULE24]
	assign mode     = sync_comm_pkg::mode_t'(
		cfg_q[sync_comm_pkg::CFG_MODE +: 3]);

	always_comb begin
		flag_d   = flag_q;
		en_d     = en_q;
		cfg_d    = cfg_q;
		pat1_d   = pat1_q;
		pat2_d   = pat2_q;
		ivl_d    = ivl_q;
		xbr_d    = xbr_q;
		xsr_d    = xsr_q;
		empty_d  = empty_q;
		load_d   = 1'b0;
		elap_d   = elap_q;
		miss_d   = miss_q;
		rx_shift = 1'b0;
		tx_shift = 1'b0;
		cmd      = 5'h00;
		// the shifter takes the old buffer before a same-cycle write lands
		if (en_q[sync_comm_pkg::EN_TXON] && TX_CHAR_DONE
			&& !empty_q) begin
			xsr_d   = xbr_q; // [RULE13]
			load_d  = 1'b1;
			empty_d = 1'b1;
		end
		if (wr) begin
			if (sel >= sync_comm_pkg::SEL_EN) begin
				cmd = sel - sync_comm_pkg::SEL_EN;
				if (cmd < 5'(NE)) begin
					en_d[cmd[2:0]] = pin_q.wbit;
				end
				if (cmd == 5'(sync_comm_pkg::EN_TIMER)) begin
					elap_d = 1'b0;
					miss_d = 1'b0;
				end
			end else if (sel >= sync_comm_pkg::SEL_FLAG) begin
				cmd = sel - sync_comm_pkg::SEL_FLAG;
				flag_d[cmd[2:0]] = pin_q.wbit; // [RULE8]
			end else if (flag_q[sync_comm_pkg::FL_CFG]) begin
				if (sel <= sync_comm_pkg::SEL_CFG_TOP) begin
					cfg_d[sel[3:0]] = pin_q.wbit;
				end
				if (sel == sync_comm_pkg::SEL_CFG_TOP) begin
					flag_d[sync_comm_pkg::FL_CFG] = 1'b0; // [RULE23]
				end
			end else if (flag_q[sync_comm_pkg::FL_PAT1]) begin
				if (sel <= sync_comm_pkg::SEL_PAT_TOP) begin
					pat1_d[sel[3:0]] = pin_q.wbit; // [RULE9]
				end
			end else if (flag_q[sync_comm_pkg::FL_PAT2]) begin
				if (sel <= sync_comm_pkg::SEL_PAT_TOP) begin
					pat2_d[sel[3:0]] = pin_q.wbit; // [RULE10]
				end
			end else if (flag_q[sync_comm_pkg::FL_IVL]) begin
				if (sel <= sync_comm_pkg::SEL_IVL_TOP) begin
					ivl_d[sel[2:0]] = pin_q.wbit; // [RULE1]
				end
			end else if (flag_q[sync_comm_pkg::FL_RXC]) begin
				rx_shift = sel <= sync_comm_pkg::SEL_PAT_TOP; // [RULE3]
			end else if (flag_q[sync_comm_pkg::FL_TXC]) begin
				tx_shift = sel <= sync_comm_pkg::SEL_PAT_TOP; // [RULE6]
			end else if (sel <= sync_comm_pkg::SEL_CHR_TOP) begin
				xbr_d[sel[3:0]] = pin_q.wbit; // [RULE12]
				empty_d         = 1'b0;
				// [RULE14]
				tx_shift = flag_q[sync_comm_pkg::FL_TXB];
			end else if (flag_q[sync_comm_pkg::FL_TXB]) begin
				tx_shift = sel <= sync_comm_pkg::SEL_PAT_TOP; // [RULE6]
			end
		end
		// a timer event beats a clear in the same cycle
		if (tick) begin
			miss_d = elap_q;
			elap_d = 1'b1;
		end
	end

	// bisync style mode refills with the first pattern, others the second
	always_comb begin
		fill_d = pat2_q; // [RULE11]
		if (mode == sync_comm_pkg::MD_SYNC2) begin
			fill_d = pat1_q; // [RULE11]
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			flag_q  <= '0;
			en_q    <= '0;
			cfg_q   <= sync_comm_pkg::CFG_RST;
			pat1_q  <= sync_comm_pkg::PAT_RST;
			pat2_q  <= sync_comm_pkg::PAT_RST;
			fill_q  <= sync_comm_pkg::PAT_RST;
			ivl_q   <= sync_comm_pkg::IVL_RST;
			xbr_q   <= sync_comm_pkg::CHR_RST;
			xsr_q   <= sync_comm_pkg::CHR_RST;
			empty_q <= 1'b1;
			load_q  <= 1'b0;
			elap_q  <= 1'b0;
			miss_q  <= 1'b0;
		end else begin
			flag_q  <= flag_d;
			en_q    <= en_d;
			cfg_q   <= cfg_d;
			pat1_q  <= pat1_d;
			pat2_q  <= pat2_d;
			fill_q  <= fill_d;
			ivl_q   <= ivl_d;
			xbr_q   <= xbr_d;
			xsr_q   <= xsr_d;
			empty_q <= empty_d;
			load_q  <= load_d;
			elap_q  <= elap_d;
			miss_q  <= miss_d;
		end
	end

	check_sum_reg #(.W(sync_comm_pkg::CRC_W)) u_rx_crc (
		.clk   (CLOCK),
		.rst   (SYS_RST),
		.shift (rx_shift),
		.din   (pin_q.wbit),
		.poly  (sync_comm_pkg::poly_t'(cfg_q[sync_comm_pkg::CFG_POLY +: 2])),
		.crc   (rx_crc)
	);

	check_sum_reg #(.W(sync_comm_pkg::CRC_W)) u_tx_crc (
		.clk   (CLOCK),
		.rst   (SYS_RST),
		.shift (tx_shift),
		.din   (pin_q.wbit),
		.poly  (sync_comm_pkg::poly_t'(cfg_q[sync_comm_pkg::CFG_POLY +: 2])),
		.crc   (tx_crc)
	);

	interval_timer #(.W(sync_comm_pkg::IVL_W), .TICK(TICK_CYC)) u_timer (
		.clk      (CLOCK),
		.rst      (SYS_RST),
		.interval (ivl_q), // [RULE2]
		.elapsed  (tick)
	);

	// -----------------------------------------------------------------
	// receive holding register
	// -----------------------------------------------------------------
	logic [8:0] rhr_q, rhr_d;

	always_comb begin
		rhr_d = rhr_q;
		if (RX_CHAR_VALID) begin
			rhr_d = RX_CHAR;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			rhr_q <= sync_comm_pkg::CHR_RST;
		end else begin
			rhr_q <= rhr_d;
		end
	end

	// -----------------------------------------------------------------
	// input select map and serial read
	// -----------------------------------------------------------------
	logic [31:0] in_bits;
	logic [15:0] crc_view;
	logic [2:0]  mode_bits;
	logic        frame_md, async_md;
	logic [4:0]  irq;
	logic        read_q, read_d;
	logic        oe_q, oe_d;

	always_comb begin
		frame_md = mode == sync_comm_pkg::MD_FRAME;
		async_md = mode == sync_comm_pkg::MD_ASY2
			|| mode == sync_comm_pkg::MD_ASY1;
		mode_bits = 3'h0; // [RULE20]
		if (frame_md) begin
			mode_bits = {STATUS.frame_abort, STATUS.frame_holding_loaded,
				STATUS.frame_holding_overrun};
		end else if (async_md) begin
			mode_bits = {STATUS.start_bit_seen, STATUS.first_bit_seen,
				STATUS.framing_error};
		end
		irq[4] = STATUS.modem_status_changed && en_q[sync_comm_pkg::EN_MODEM];
		irq[3] = elap_q && en_q[sync_comm_pkg::EN_TIMER];
		irq[2] = STATUS.tx_abort && en_q[sync_comm_pkg::EN_ABORT]
			&& (mode == sync_comm_pkg::MD_GEN || frame_md);
		irq[1] = empty_q && en_q[sync_comm_pkg::EN_TXON]
			&& en_q[sync_comm_pkg::EN_EMPTY];
		irq[0] = (STATUS.rx_buffer_loaded || STATUS.frame_holding_loaded
			|| STATUS.frame_abort) && en_q[sync_comm_pkg::EN_RX];
		in_bits = {|irq, any_flag, STATUS.modem_status_changed, // [RULE18]
			STATUS.cts, STATUS.dsr, STATUS.auto_send_request, elap_q,
			miss_q, STATUS.tx_abort, empty_q, STATUS.rx_buffer_loaded,
			irq, pin_q.rx_level, mode_bits, STATUS.rx_overrun, // [RULE19]
			frame_md ? STATUS.zero_error : STATUS.parity_error, // [RULE20]
			frame_md ? STATUS.flag_detected : STATUS.receive_error,
			rhr_q}; // [RULE21]
		// bit 0 of the select reaches the top of the register first
		for (int i = 0; i < 16; i++) begin
			crc_view[i] = rx_crc[15 - i]; // [RULE5]
			if (flag_q[sync_comm_pkg::FL_TXC]
				|| flag_q[sync_comm_pkg::FL_TXB]) begin
				crc_view[i] = tx_crc[15 - i]; // [RULE7]
			end else if (!flag_q[sync_comm_pkg::FL_RXC]) begin
				crc_view[i] = 1'b0;
			end
		end
		if (any_flag) begin
			in_bits[15:0] = crc_view; // [RULE17] [RULE4]
		end
		read_d = in_bits[sel] && !pin_q.ce_n; // [RULE15]
		oe_d   = !pin_q.ce_n; // [RULE16]
	end

	always_ff @(posedge CLOCK) begin
		if (SYS_RST) begin
			read_q <= 1'b0;
			oe_q   <= 1'b0;
		end else begin
			read_q <= read_d;
			oe_q   <= oe_d;
		end
	end

	assign SERIAL_READ_LINE = read_q;
	assign SERIAL_READ_OE   = oe_q;
	assign CONFIG           = cfg_q;
	assign SYNC_PATTERN     = pat1_q;
	assign FILL_PATTERN     = fill_q;
	assign TX_SHIFTER       = xsr_q;
	assign TX_SHIFT_LOAD    = load_q;
	assign TX_ACTIVE        = en_q[sync_comm_pkg::EN_TXON];

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (SYS_RST);

	ivl_guard_a: // [RULE1]
		assert property (!flag_q[sync_comm_pkg::FL_IVL] |=> $stable(ivl_q))
		else $error("interval changed without its load flag");
	rx_crc_cause_a: // [RULE3]
		assert property (!$stable(rx_crc) |-> $past(wr
			&& flag_q[sync_comm_pkg::FL_RXC]))
		else $error("receive check-sum moved without a write");
	pat1_guard_a: // [RULE9]
		assert property (!$stable(pat1_q) |-> $past(wr
			&& flag_q[sync_comm_pkg::FL_PAT1]))
		else $error("first pattern changed without its flag");
	xbr_guard_a: // [RULE12]
		assert property (!$stable(xbr_q) |-> $past(wr
			&& (!any_flag || flag_q[sync_comm_pkg::FL_TXB])))
		else $error("tx buffer loaded while blocked");
	shifter_move_a: // [RULE13]
		assert property (en_q[sync_comm_pkg::EN_TXON] && TX_CHAR_DONE
			&& !empty_q |=> TX_SHIFT_LOAD && TX_SHIFTER == $past(xbr_q))
		else $error("buffer not moved to shifter");
	tx_flag_hold_a: // [RULE8]
		assert property (flag_q[sync_comm_pkg::FL_TXB] && !(wr
			&& sel == sync_comm_pkg::SEL_FLAG + 5'(sync_comm_pkg::FL_TXB))
			|=> flag_q[sync_comm_pkg::FL_TXB])
		else $error("tx buffer flag dropped without command");
	cfg_flag_clear_a: // [RULE23]
		assert property (wr && flag_q[sync_comm_pkg::FL_CFG]
			&& sel == sync_comm_pkg::SEL_CFG_TOP
			|=> !flag_q[sync_comm_pkg::FL_CFG])
		else $error("control flag survived bit 11 write");
	read_release_a: // [RULE16]
		assert property (pin_q.ce_n |=> !SERIAL_READ_OE && !SERIAL_READ_LINE)
		else $error("read line driven while disabled");
	flag_status_a: // [RULE24]
		assert property (pin_q.sel == 5'h1E && !pin_q.ce_n
			|=> SERIAL_READ_LINE == $past(|flag_q))
		else $error("flag status bit wrong");
endmodule
`default_nettype wire

/* File: dv/host_port_model.sv */
// Purpose: host side of the bit-serial register port
// Assumes: tasks are entered just after a falling CLOCK edge
// Notes:   each write pin phase lasts 3 cycles and each read phase 4 so the synchronisers see it
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
	input  wire logic       CLOCK,
	input  wire logic       LINE,
	input  wire logic       OE,
	output logic            CE_N,
	output logic [4:0]      SEL,
	output logic            WBIT,
	output logic            STROBE
);
	initial begin
		CE_N = 1'b1;
		SEL = 5'h00;
		WBIT = 1'b0;
		STROBE = 1'b0;
	end
	// enable stays low after a write; rd raises it again
	task automatic wr(input logic [4:0] a, input logic b);
		CE_N = 1'b0;
		SEL = a;
		WBIT = b;
		repeat (3) @(negedge CLOCK);
		STROBE = 1'b1;
		repeat (3) @(negedge CLOCK);
		STROBE = 1'b0;
		repeat (3) @(negedge CLOCK);
	endtask
	// an undriven line comes back unknown so no match can pass
	task automatic rd(input logic [4:0] a, output logic v);
		CE_N = 1'b0;
		SEL = a;
		repeat (4) @(negedge CLOCK);
		v = OE ? LINE : 1'bx;
		CE_N = 1'b1;
		repeat (4) @(negedge CLOCK);
	endtask
endmodule
`default_nettype wire

/* File: dv/sync_comm_regs_tb.sv */
// Purpose: self-checking bench of the register access block
// Assumes: short timer tick, host model paces every pin phase
// Notes:   scenarios run in order; config is written last
`timescale 1ns/1ps
`default_nettype none
module sync_comm_regs_tb;
	logic                      clk = 1'b0;
	logic                      rst = 1'b1;
	logic                      rxl = 1'b1;
	logic                      rxv = 1'b0;
	logic                      txd = 1'b0;
	logic [8:0]                rxc = 9'h000;
	sync_comm_pkg::rx_status_t st = '0;
	wire logic                 ce_n, wb, stb, line, oe, txld, txon;
	wire logic [4:0]           sel;
	wire logic [11:0]          cfg;
	wire logic [9:0]           synp, fill;
	wire logic [8:0]           txs;
	int                        bad_count = 0;
	int                        cmp_count = 0;
	int                        cyc = 0;
	logic [15:0]               v;
	always #10 clk = ~clk;
	sync_comm_regs #(.TICK_CYC(2)) u_dut (.CLOCK(clk), .SYS_RST(rst),
		.CE_N(ce_n), .BIT_SELECT_LINES(sel), .SERIAL_WRITE_LINE(wb),
		.SERIAL_BIT_STROBE(stb), .SERIAL_RECEIVE_LEVEL(rxl),
		.STATUS(st), .RX_CHAR(rxc), .RX_CHAR_VALID(rxv),
		.TX_CHAR_DONE(txd), .SERIAL_READ_LINE(line),
		.SERIAL_READ_OE(oe), .CONFIG(cfg), .SYNC_PATTERN(synp),
		.FILL_PATTERN(fill), .TX_SHIFTER(txs), .TX_SHIFT_LOAD(txld),
		.TX_ACTIVE(txon));
	host_port_model u_host (.CLOCK(clk), .LINE(line), .OE(oe),
		.CE_N(ce_n), .SEL(sel), .WBIT(wb), .STROBE(stb));
	task automatic chk(input string n, input logic [15:0] x,
		input logic [15:0] s);
		cmp_count++;
		if (s !== x) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic c1(input string n, input logic [4:0] a, input logic x);
		logic b;
		u_host.rd(a, b);
		chk(n, {15'h0000, x}, {15'h0000, b});
	endtask
	task automatic wrn(input logic [4:0] a, input int n,
		input logic [15:0] d);
		for (int i = 0; i < n; i++) u_host.wr(a + 5'(i), d[i]);
	endtask
	// bits are gathered first-read into the top of the result
	task automatic rdn(input logic [4:0] a, input int n, input int s,
		output logic [15:0] r);
		logic b;
		r = 16'h0000;
		for (int i = 0; i < n; i++) begin
			u_host.rd(a + 5'(i * s), b);
			r = {r[14:0], b};
		end
	endtask
	function automatic logic [15:0] crc(input logic [15:0] c,
		input logic [15:0] d, input int n);
		for (int i = 0; i < n; i++)
			c = {c[14:0], 1'b0} ^ ((d[i] ^ c[15]) ? 16'h8005 : 16'h0000);
		return c;
	endfunction
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc > 20000) begin
			bad_count++;
			report_and_stop();
		end
	end
	task automatic t_idle();
		chk("oe idle", 16'h0000, {15'h0000, oe});
		c1("tx empty", 5'h16, 1'b1);
		c1("rx level", 5'h0F, 1'b1);
		c1("any flag", 5'h1E, 1'b0);
		$display("idle done");
	endtask
	task automatic t_pat();
		u_host.wr(5'h11, 1'b1);
		wrn(5'h00, 10, 16'h02A5);
		c1("flag held", 5'h1E, 1'b1);
		u_host.wr(5'h11, 1'b0);
		chk("sync", 16'h02A5, {6'h00, synp});
		u_host.wr(5'h12, 1'b1);
		wrn(5'h00, 10, 16'h015A);
		u_host.wr(5'h12, 1'b0);
		chk("fill", 16'h015A, {6'h00, fill});
		chk("sync kept", 16'h02A5, {6'h00, synp});
		$display("pattern done");
	endtask
	task automatic t_crc();
		u_host.wr(5'h14, 1'b1);
		wrn(5'h00, 10, 16'h03C5);
		rdn(5'h00, 16, 1, v);
		chk("rx crc", crc(16'h0000, 16'h03C5, 10), v);
		u_host.wr(5'h14, 1'b0);
		$display("crc done");
	endtask
	task automatic t_tx();
		u_host.wr(5'h1C, 1'b1);
		chk("tx on", 16'h0001, {15'h0000, txon});
		wrn(5'h00, 9, 16'h01A3);
		c1("tx full", 5'h16, 1'b0);
		txd = 1'b1;
		@(negedge clk);
		txd = 1'b0;
		chk("shift load", 16'h0001, {15'h0000, txld});
		repeat (2) @(negedge clk);
		chk("load end", 16'h0000, {15'h0000, txld});
		chk("shifter", 16'h01A3, {7'h00, txs});
		c1("tx empty", 5'h16, 1'b1);
		u_host.wr(5'h16, 1'b1);
		wrn(5'h00, 9, 16'h00B7);
		rdn(5'h00, 16, 1, v);
		chk("tx crc", crc(16'h0000, 16'h00B7, 9), v);
		u_host.wr(5'h16, 1'b0);
		c1("tx loaded", 5'h16, 1'b0);
		u_host.wr(5'h15, 1'b1);
		wrn(5'h00, 10, 16'h0155);
		rdn(5'h00, 16, 1, v);
		chk("txc", crc(crc(16'h0000, 16'h00B7, 9), 16'h0155, 10), v);
		u_host.wr(5'h15, 1'b0);
		$display("tx done");
	endtask
	task automatic t_rx();
		st.cts = 1'b1;
		st.rx_overrun = 1'b1;
		st.rx_buffer_loaded = 1'b1;
		rxc = 9'h15D;
		rxv = 1'b1;
		@(negedge clk);
		rxv = 1'b0;
		rdn(5'h08, 9, -1, v);
		chk("rx char", 16'h015D, v);
		c1("rx loaded", 5'h15, 1'b1);
		c1("cts", 5'h1C, 1'b1);
		c1("overrun", 5'h0B, 1'b1);
		$display("rx done");
	endtask
	task automatic t_tmr();
		u_host.wr(5'h13, 1'b1);
		wrn(5'h00, 8, 16'h0003);
		u_host.wr(5'h13, 1'b0);
		repeat (40) @(negedge clk);
		c1("elapsed", 5'h19, 1'b1);
		u_host.wr(5'h18, 1'b1);
		repeat (40) @(negedge clk);
		c1("elapsed again", 5'h19, 1'b1);
		c1("timer irq", 5'h13, 1'b1);
		c1("timer missed", 5'h18, 1'b1);
		$display("timer done");
	endtask
	task automatic t_cfg();
		st.frame_abort = 1'b1;
		st.zero_error  = 1'b1;
		u_host.wr(5'h10, 1'b1);
		u_host.wr(5'h06, 1'b1);
		u_host.wr(5'h0B, 1'b1);
		c1("cfg flag off", 5'h1E, 1'b0);
		chk("cfg bit", 16'h0001, {15'h0000, cfg[11]});
		c1("frame abort", 5'h0E, 1'b1);
		c1("zero error", 5'h0A, 1'b1);
		u_host.wr(5'h10, 1'b1);
		u_host.wr(5'h07, 1'b1);
		u_host.wr(5'h0B, 1'b1);
		chk("cfg", 16'h08C0, {4'h0, cfg});
		chk("fill mode 3", 16'h02A5, {6'h00, fill});
		c1("abort masked", 5'h0E, 1'b0);
		$display("config done");
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_idle();
		t_pat();
		t_crc();
		t_tx();
		t_rx();
		t_tmr();
		t_cfg();
		report_and_stop();
	end
endmodule
`default_nettype wire
